/* sdr_defs.vh */
/*
  Shared constants for the synchronous DRAM command core: command codes,
  register offsets, field positions, reset values and timing counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SDR_DEFS_VH
`define SDR_DEFS_VH

// {chip select, row strobe, column strobe, write enable}, all active low
`define SDR_CMD_MODE      4'h0
`define SDR_CMD_REFRESH   4'h1
`define SDR_CMD_PRECHARGE 4'h2
`define SDR_CMD_ACTIVATE  4'h3
`define SDR_CMD_WRITE     4'h4
`define SDR_CMD_READ      4'h5
`define SDR_CMD_TERMINATE 4'h6
`define SDR_CMD_NOP       4'h7

`define SDR_OFF_CFG       8'h00
`define SDR_OFF_STAT      8'h04

// config register mirrors the mode register layout
`define SDR_CFG_BL_LSB    0
`define SDR_CFG_BT_BIT    3
`define SDR_CFG_CL_LSB    4
`define SDR_CFG_WBM_BIT   9
`define SDR_CFG_RST       10'h022
`define SDR_BL_PAGE       3'h7
`define SDR_CL_TWO        3'h2

`define SDR_STAT_PD_BIT   4
`define SDR_STAT_PDA_BIT  5
`define SDR_STAT_SUSP_BIT 6
`define SDR_STAT_BUSY_BIT 7

`define SDR_CLK_MHZ       25
`define SDR_WRITE_RECOVERY_TIME_NS       15
`define SDR_WRITE_RECOVERY_TIME_CYC      ((`SDR_WRITE_RECOVERY_TIME_NS * `SDR_CLK_MHZ + 999) / 1000)

`endif

/* sdr_store.v */
/*
  Flip-flop data array for the command core, one word per bank and column.
  Assumes the caller masks writes and forms the index from bank and column.
*/
`default_nettype none

module sdr_store #(
  parameter DW = 8,
  parameter AW = 6
) (
  input  wire          clk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output wire [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];

endmodule

`default_nettype wire

/* sdr_banks.v */
/*
  Per-bank open/idle tracking with self-timed auto precharge countdown.
  Assumes at most one activate or precharge per edge and bank index 0..3.
*/
`default_nettype none

module sdr_banks #(
  parameter TW = 4
) (
  input  wire          clk,
  input  wire          reset_n,
  input  wire          act_en,
  input  wire [1:0]    act_bank,
  input  wire          pre_en,
  input  wire          pre_all,
  input  wire [1:0]    pre_bank,
  input  wire          apa_en,
  input  wire [1:0]    apa_bank,
  input  wire [TW-1:0] apa_dly,
  input  wire          apb_en,
  input  wire [1:0]    apb_bank,
  input  wire [TW-1:0] apb_dly,
  output reg  [3:0]    active
);

  reg [TW-1:0] tmr [0:3];
  integer      i;

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      active <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        tmr[i] <= {TW{1'b0}};
    end
    else
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        if (act_en && act_bank == i[1:0])
        begin
          active[i] <= 1'b1;
          tmr[i]    <= {TW{1'b0}};
        end
        else if (pre_en && (pre_all || pre_bank == i[1:0]))
        begin
          active[i] <= 1'b0;
          tmr[i]    <= {TW{1'b0}};
        end
        else if ((apa_en && apa_bank == i[1:0]) || (apb_en && apb_bank == i[1:0]))
        begin
          if ((apa_en && apa_bank == i[1:0]) ? (apa_dly == {TW{1'b0}}) : (apb_dly == {TW{1'b0}}))
            active[i] <= 1'b0;
          else
            tmr[i] <= (apa_en && apa_bank == i[1:0]) ? apa_dly : apb_dly;
        end
        else if (tmr[i] != {TW{1'b0}})
        begin
          // write recovery runs in real time, not on the suspended clock
          tmr[i] <= tmr[i] - {{(TW-1){1'b0}}, 1'b1};
          if (tmr[i] == {{(TW-1){1'b0}}, 1'b1})
            active[i] <= 1'b0;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* sdr_core.v */
/*
  Command core of a four-bank synchronous DRAM: command decode, bursts,
  clock suspend, power-down, precharge, concurrent auto precharge, and an
  APB slave holding the mode configuration and a status word.
  Assumes pins are synchronous to ref_clk and the controller keeps its timing.
*/
`default_nettype none
`include "sdr_defs.vh"

module sdr_core #(
  parameter DW   = 8,
  parameter COLW = 4
) (
  input  wire          ref_clk,
  input  wire          reset_n,
  input  wire [7:0]    paddr,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  input  wire          cke,
  input  wire          cs_n,
  input  wire          ras_n,
  input  wire          cas_n,
  input  wire          we_n,
  input  wire [11:0]   addr,
  input  wire          precharge_all_select_bit,
  input  wire          bank_select_low,
  input  wire          bank_select_high,
  input  wire          dqm,
  input  wire [DW-1:0] dq_in,
  output wire [DW-1:0] dq_out,
  output wire          dq_oe
);

  localparam integer WRITE_RECOVERY_TIME_I   = (`SDR_WRITE_RECOVERY_TIME_CYC < 1) ? 1 : `SDR_WRITE_RECOVERY_TIME_CYC;
  localparam [3:0]   WRITE_RECOVERY_TIME_CYC = WRITE_RECOVERY_TIME_I[3:0];
  localparam         AWI      = COLW + 2;

  function [10:0] burst_len;
    input [2:0] code;
    input       single;
    begin
      if (single)
        burst_len = 11'h001;
      else
        case (code)
          3'h0:    burst_len = 11'h001;
          3'h1:    burst_len = 11'h002;
          3'h2:    burst_len = 11'h004;
          3'h3:    burst_len = 11'h008;
          default: burst_len = 11'h400;
        endcase
    end
  endfunction

  function [9:0] burst_col;
    input [9:0]  start;
    input [9:0]  idx;
    input [10:0] len;
    input        ilv;
    reg   [9:0]  mask;
    begin
      mask      = len[9:0] - 10'h001;
      burst_col = (start & ~mask) | ((ilv ? (start ^ idx) : (start + idx)) & mask);
    end
  endfunction

  reg  [9:0]    cfg_r;
  reg           cke_r;
  reg           pd_r;
  reg           pd_act_r;
  reg           bst_act_r;
  reg           bst_wr_r;
  reg           bst_ap_r;
  reg           bst_full_r;
  reg  [1:0]    bst_bank_r;
  reg  [9:0]    bst_start_r;
  reg  [9:0]    bst_idx_r;
  reg  [10:0]   bst_len_r;
  reg  [2:0]    pv_r;
  reg  [DW-1:0] pd0_r;
  reg  [DW-1:0] pd1_r;
  reg  [DW-1:0] pd2_r;
  reg  [1:0]    dqm_r;

  wire [3:0]    bank_active;
  wire [DW-1:0] store_rdata;
  wire [3:0]    cmd = {cs_n, ras_n, cas_n, we_n};
  wire [1:0]    cmd_bank = {bank_select_high, bank_select_low};
  wire [2:0]    cfg_bl = cfg_r[`SDR_CFG_BL_LSB +: 3];
  wire          cfg_bt = cfg_r[`SDR_CFG_BT_BIT];
  wire [2:0]    cfg_cl = cfg_r[`SDR_CFG_CL_LSB +: 3];
  wire          cfg_wbm = cfg_r[`SDR_CFG_WBM_BIT];

  // internal edge happens only if the previous edge saw clock enable high
  wire          tick = cke_r & ~pd_r;
  wire          idle_cmd = cs_n | (cmd == `SDR_CMD_NOP);
  wire          bank_ok = bank_active[cmd_bank];
  wire          is_rd = tick & ~cs_n & (cmd == `SDR_CMD_READ) & bank_ok;
  wire          is_wr = tick & ~cs_n & (cmd == `SDR_CMD_WRITE) & bank_ok;
  wire          is_act = tick & ~cs_n & (cmd == `SDR_CMD_ACTIVATE) & ~bank_ok;
  wire          is_pre = tick & ~cs_n & (cmd == `SDR_CMD_PRECHARGE);
  wire          is_bst = tick & ~cs_n & (cmd == `SDR_CMD_TERMINATE);
  wire          is_mrs = tick & ~cs_n & (cmd == `SDR_CMD_MODE);
  wire          new_cmd = is_rd | is_wr;
  wire          pre_hits = is_pre & (precharge_all_select_bit | (cmd_bank == bst_bank_r));

  // write burst mode collapses writes to one column
  wire          new_single = is_wr & cfg_wbm;
  wire [10:0]   new_len = burst_len(cfg_bl, new_single);
  wire          new_full = (cfg_bl == `SDR_BL_PAGE) & ~new_single;

  wire          cont = tick & bst_act_r & ~new_cmd & ~is_bst & ~pre_hits;
  wire          elem_do = new_cmd | cont;
  wire          elem_wr = new_cmd ? is_wr : bst_wr_r;
  wire [1:0]    elem_bank = new_cmd ? cmd_bank : bst_bank_r;
  wire [10:0]   elem_len = new_cmd ? new_len : bst_len_r;
  wire [9:0]    elem_idx = new_cmd ? 10'h000 : bst_idx_r;
  wire          elem_full = new_cmd ? new_full : bst_full_r;
  wire          elem_ap = new_cmd ? precharge_all_select_bit : bst_ap_r;
  wire [9:0]    elem_col = new_cmd ? burst_col(addr[9:0], 10'h000, new_len, cfg_bt)
                                   : burst_col(bst_start_r, bst_idx_r, bst_len_r, cfg_bt);
  wire          elem_last = elem_do & ~elem_full & ({1'b0, elem_idx} == (elem_len - 11'h001));

  // a new access to another bank hands the running auto precharge its close
  wire          intr_ap = new_cmd & bst_act_r & bst_ap_r & (cmd_bank != bst_bank_r);
  wire [3:0]    intr_dly = bst_wr_r ? WRITE_RECOVERY_TIME_CYC : 4'h0;
  wire          done_ap = elem_last & elem_ap;
  wire [3:0]    done_dly = elem_wr ? WRITE_RECOVERY_TIME_CYC : 4'h0;

  wire          pipe_busy = |pv_r;
  wire          pd_enter = tick & ~cke & idle_cmd & ~bst_act_r & ~pipe_busy;
  wire          pd_exit = pd_r & cke & idle_cmd;

  wire [AWI-1:0] store_idx = {elem_bank, elem_col[COLW-1:0]};

  // input mask acts on data at the same edge
  wire          store_we = elem_do & elem_wr & ~dqm;

  sdr_store #(
    .DW (DW),
    .AW (AWI)
  ) u_store (
    .clk   (ref_clk),
    .we    (store_we),
    .waddr (store_idx),
    .wdata (dq_in),
    .raddr (store_idx),
    .rdata (store_rdata)
  );

  sdr_banks #(
    .TW (4)
  ) u_banks (
    .clk      (ref_clk),
    .reset_n  (reset_n),
    .act_en   (is_act),
    .act_bank (cmd_bank),
    .pre_en   (is_pre),
    .pre_all  (precharge_all_select_bit),
    .pre_bank (cmd_bank),
    .apa_en   (intr_ap),
    .apa_bank (bst_bank_r),
    .apa_dly  (intr_dly),
    .apb_en   (done_ap),
    .apb_bank (elem_bank),
    .apb_dly  (done_dly),
    .active   (bank_active)
  );

  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      cke_r    <= 1'b1;
      pd_r     <= 1'b0;
      pd_act_r <= 1'b0;
    end
    else
    begin
      cke_r <= cke;
      if (pd_enter)
      begin
        pd_r     <= 1'b1;
        pd_act_r <= |bank_active;
      end
      else if (pd_exit)
      begin
        pd_r     <= 1'b0;
        pd_act_r <= 1'b0;
      end
    end
  end

  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      bst_act_r   <= 1'b0;
      bst_wr_r    <= 1'b0;
      bst_ap_r    <= 1'b0;
      bst_full_r  <= 1'b0;
      bst_bank_r  <= 2'h0;
      bst_start_r <= 10'h000;
      bst_idx_r   <= 10'h000;
      bst_len_r   <= 11'h001;
    end
    else if (new_cmd)
    begin
      bst_act_r   <= ~elem_last;
      bst_wr_r    <= is_wr;
      bst_ap_r    <= precharge_all_select_bit;
      bst_full_r  <= new_full;
      bst_bank_r  <= cmd_bank;
      bst_start_r <= addr[9:0];
      bst_idx_r   <= 10'h001;
      bst_len_r   <= new_len;
    end
    else if (is_bst | pre_hits)
    begin
      bst_act_r <= 1'b0;
    end
    else if (cont)
    begin
      // counter only advances on internal edges
      bst_idx_r <= bst_idx_r + 10'h001;
      bst_act_r <= ~elem_last;
    end
  end

  // read data pipeline, tapped by CAS latency; frozen while suspended
  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      pv_r  <= 3'h0;
      pd0_r <= {DW{1'b0}};
      pd1_r <= {DW{1'b0}};
      pd2_r <= {DW{1'b0}};
      dqm_r <= 2'h0;
    end
    else if (tick)
    begin
      // a registered write tri-states any read still in flight
      pv_r  <= {pv_r[1] & ~is_wr, pv_r[0] & ~is_wr, elem_do & ~elem_wr};
      pd0_r <= store_rdata;
      pd1_r <= pd0_r;
      pd2_r <= pd1_r;
      dqm_r <= {dqm_r[0], dqm};
    end
  end

  wire cl_two = (cfg_cl == `SDR_CL_TWO);
  assign dq_out = cl_two ? pd1_r : pd2_r;
  // output mask two edges late; buffers dark in power-down
  assign dq_oe = (cl_two ? pv_r[1] : pv_r[2]) & ~dqm_r[1] & ~pd_r;

  wire        apb_setup = psel & ~penable;
  wire        apb_acc = psel & penable;
  wire        hit_cfg = (paddr == `SDR_OFF_CFG);
  wire        hit_stat = (paddr == `SDR_OFF_STAT);
  wire [7:0]  stat_word;

  assign stat_word[3:0]               = bank_active;
  assign stat_word[`SDR_STAT_PD_BIT]   = pd_r;
  assign stat_word[`SDR_STAT_PDA_BIT]  = pd_act_r;
  assign stat_word[`SDR_STAT_SUSP_BIT] = ~cke_r & ~pd_r;
  assign stat_word[`SDR_STAT_BUSY_BIT] = bst_act_r | pipe_busy;

  assign pready  = 1'b1;
  assign pslverr = apb_acc & ~hit_cfg & ~hit_stat;

  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      cfg_r  <= `SDR_CFG_RST;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      if (apb_acc & pwrite & hit_cfg)
        cfg_r <= pwdata[9:0];
      else if (is_mrs)
        cfg_r <= addr[9:0];
      if (apb_setup)
        prdata <= hit_cfg ? {22'h000000, cfg_r} : (hit_stat ? {24'h000000, stat_word} : 32'h0000_0000);
    end
  end

endmodule

`default_nettype wire

/* sdr_core_sva.sv */
/*
  Port checker for the command core: APB answers, clock suspend, masking.
  Assumes one ref_clk domain with synchronous active-low reset_n.
*/
`default_nettype none
`include "sdr_defs.vh"

module sdr_core_sva #(
  parameter DW = 8
) (
  input wire logic          ref_clk,
  input wire logic          reset_n,
  input wire logic [7:0]    paddr,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          cke,
  input wire logic          cs_n,
  input wire logic          ras_n,
  input wire logic          cas_n,
  input wire logic          we_n,
  input wire logic          dqm,
  input wire logic [DW-1:0] dq_out,
  input wire logic          dq_oe
);
  logic [3:0] cmd_w;
  logic       unmap_w;
  assign cmd_w = {cs_n, ras_n, cas_n, we_n};
  assign unmap_w = (paddr != `SDR_OFF_CFG) && (paddr != `SDR_OFF_STAT);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_err_unmap: assert property (psel && penable && unmap_w |-> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (psel && penable && !unmap_w |-> !pslverr)
    else $error("error on mapped access");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access phase");
  a_unmap_zero: assert property (psel && penable && !pwrite && unmap_w |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_susp_hold: assert property (!cke |=> ##1 ($stable(dq_out) && $stable(dq_oe)))
    else $error("outputs moved on a suspended edge");
  a_mask_out: assert property ($past(cke) && cke && dqm |-> ##2 !dq_oe)
    else $error("masked output still driven");
  a_wr_cut: assert property ($past(cke) && cmd_w == `SDR_CMD_WRITE |=> (!dq_oe) [*2])
    else $error("read data driven after write");
endmodule

bind sdr_core sdr_core_sva #(.DW(DW)) i_sdr_core_sva (.ref_clk, .reset_n, .paddr, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .cke, .cs_n, .ras_n, .cas_n, .we_n, .dqm, .dq_out, .dq_oe);

`default_nettype wire

/* ssp_ctl_model.sv */
/*
  Memory controller model driving command, address, mask and data pins.
  Assumes each call of op starts right after a rising ref_clk edge.
*/
`default_nettype none
`include "sdr_defs.vh"

module ssp_ctl_model #(
  parameter DW = 8
) (
  input  wire logic          ref_clk,
  output var  logic          cke,
  output var  logic          cs_n,
  output var  logic          ras_n,
  output var  logic          cas_n,
  output var  logic          we_n,
  output var  logic [11:0]   addr,
  output var  logic          precharge_all_select_bit,
  output var  logic          bank_select_low,
  output var  logic          bank_select_high,
  output var  logic          dqm,
  output var  logic [DW-1:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {addr, precharge_all_select_bit, bank_select_low, bank_select_high, dqm, dq_in} = '0;
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = `SDR_CMD_NOP;
  end
  // pins hold until the next call, so back-to-back calls never assign twice
  task automatic op(input logic [3:0] c, input logic [1:0] b, input logic a, input logic [9:0] col,
                    input logic [DW-1:0] d, input logic m, input logic k);
    @(posedge ref_clk);
    cke <= k;
    {cs_n, ras_n, cas_n, we_n} <= c;
    addr <= {2'h0, col};
    precharge_all_select_bit <= a;
    {bank_select_high, bank_select_low} <= b;
    dqm <= m;
    dq_in <= d;
  endtask
endmodule

`default_nettype wire

/* tb_top.sv */
/*
  Testbench: APB register access plus command scenarios through the model.
  Assumes sdr_core with DW 8 and a 25 MHz ref_clk.
*/
`default_nettype none
`include "sdr_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, dq_oe, cke, cs_n, ras_n, cas_n, we_n, dqm;
  wire         precharge_all_select_bit, bank_select_low, bank_select_high;
  wire  [7:0]  dq_out, dq_in;
  wire  [11:0] addr;
  int          fails = 0;
  int          tests_run = 0;
  logic [31:0] rd;
  logic        er;
  logic [8:0]  got [16];

  always #20 ref_clk = ~ref_clk;

  sdr_core #(.DW(8), .COLW(4)) i_sdr_core (.ref_clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr, .precharge_all_select_bit,
    .bank_select_low, .bank_select_high, .dqm, .dq_in, .dq_out, .dq_oe);
  ssp_ctl_model #(.DW(8)) i_ssp_ctl_model (.ref_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr,
    .precharge_all_select_bit, .bank_select_low, .bank_select_high, .dqm, .dq_in);

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge ref_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16)
    begin
      fails++;
      print_verdict();
    end
  endtask

  task automatic stat(input logic [7:0] e);
    apb(1'b0, `SDR_OFF_STAT, 32'h0);
    `CHK(rd, {24'h0, e})
  endtask

  task automatic op(input logic [3:0] c, input logic [1:0] b, input logic a, input logic [7:0] d, input logic k);
    i_ssp_ctl_model.op(c, b, a, 10'h0, d, 1'b0, k);
  endtask

  // released data lines show the inverse of the last value
  task automatic nop(input int n);
    repeat (n) op(`SDR_CMD_NOP, 2'h0, 1'b0, ~dq_in, 1'b1);
  endtask

  task automatic wr(input logic [1:0] b, input logic [31:0] d, input logic [3:0] m);
    for (int i = 0; i < 4; i++)
      i_ssp_ctl_model.op(i == 0 ? `SDR_CMD_WRITE : `SDR_CMD_NOP, b, 1'b0, 10'h0, d[8*i+:8], m[i], 1'b1);
    nop(2);
  endtask

  task automatic grab(input logic [15:0] km, input logic [15:0] mm);
    for (int i = 0; i < 16; i++)
    begin
      i_ssp_ctl_model.op(`SDR_CMD_NOP, 2'h0, 1'b0, 10'h0, ~dq_in, mm[i], km[i]);
      got[i] = {dq_oe, dq_out};
    end
  endtask

  // entries with the top bit clear only demand an idle output
  task automatic rchk(input logic [8:0] e [6]);
    for (int i = 0; i < 6; i++)
      if (e[i][8]) `CHK(got[i+2], e[i]) else `CHK(got[i+2][8], 1'b0)
  endtask

  task automatic t_regs;
    apb(1'b0, `SDR_OFF_CFG, 32'h0);
    `CHK(rd, 32'h22)
    apb(1'b1, `SDR_OFF_STAT, 32'hff);
    stat(8'h00);
    apb(1'b1, 8'h08, 32'h3ff);
    `CHK(er, 1'b1)
    apb(1'b0, 8'h08, 32'h0);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    apb(1'b0, `SDR_OFF_CFG, 32'h0);
    `CHK(rd, 32'h22)
    $display("test regs finished");
  endtask

  task automatic t_pre;
    for (int b = 0; b < 3; b++)
      op(`SDR_CMD_ACTIVATE, b[1:0], 1'b0, ~dq_in, 1'b1);
    nop(2);
    op(`SDR_CMD_PRECHARGE, 2'h1, 1'b0, ~dq_in, 1'b1);
    nop(2);
    stat(8'h05);
    op(`SDR_CMD_PRECHARGE, 2'h1, 1'b1, ~dq_in, 1'b1);
    nop(2);
    stat(8'h00);
    $display("test precharge finished");
  endtask

  task automatic t_burst;
    op(`SDR_CMD_ACTIVATE, 2'h0, 1'b0, ~dq_in, 1'b1);
    nop(2);
    wr(2'h0, 32'h44332211, 4'h0);
    wr(2'h0, 32'h88776655, 4'h4);
    op(`SDR_CMD_READ, 2'h0, 1'b0, ~dq_in, 1'b1);
    grab(16'hffff, 16'h0);
    rchk('{9'h155, 9'h166, 9'h133, 9'h188, 9'h0, 9'h0});
    apb(1'b1, `SDR_OFF_CFG, 32'h222);
    wr(2'h0, 32'hccbbaa99, 4'h0);
    op(`SDR_CMD_READ, 2'h0, 1'b0, ~dq_in, 1'b1);
    grab(16'hffff, 16'h0);
    rchk('{9'h199, 9'h166, 9'h133, 9'h188, 9'h0, 9'h0});
    apb(1'b1, `SDR_OFF_CFG, 32'h22);
    $display("test burst finished");
  endtask

  task automatic t_susp;
    op(`SDR_CMD_READ, 2'h0, 1'b0, ~dq_in, 1'b1);
    grab(16'hfffd, 16'h0);
    rchk('{9'h199, 9'h166, 9'h166, 9'h133, 9'h188, 9'h0});
    op(`SDR_CMD_READ, 2'h0, 1'b0, ~dq_in, 1'b1);
    grab(16'hffff, 16'h2);
    rchk('{9'h199, 9'h166, 9'h0, 9'h188, 9'h0, 9'h0});
    $display("test suspend finished");
  endtask

  task automatic t_cap;
    op(`SDR_CMD_ACTIVATE, 2'h1, 1'b0, ~dq_in, 1'b1);
    nop(2);
    wr(2'h1, 32'hf4f3f2f1, 4'h0);
    op(`SDR_CMD_READ, 2'h0, 1'b1, ~dq_in, 1'b1);
    op(`SDR_CMD_READ, 2'h1, 1'b0, ~dq_in, 1'b1);
    grab(16'hffff, 16'h0);
    `CHK(got[1], 9'h199)
    rchk('{9'h1f1, 9'h1f2, 9'h1f3, 9'h1f4, 9'h0, 9'h0});
    stat(8'h02);
    op(`SDR_CMD_ACTIVATE, 2'h2, 1'b0, ~dq_in, 1'b1);
    nop(2);
    op(`SDR_CMD_WRITE, 2'h1, 1'b1, 8'h5a, 1'b1);
    op(`SDR_CMD_WRITE, 2'h2, 1'b0, 8'h5b, 1'b1);
    nop(6);
    stat(8'h04);
    op(`SDR_CMD_ACTIVATE, 2'h0, 1'b0, ~dq_in, 1'b1);
    nop(2);
    op(`SDR_CMD_READ, 2'h0, 1'b1, ~dq_in, 1'b1);
    // mask read data ahead of the write so the bus never fights
    repeat (2) i_ssp_ctl_model.op(`SDR_CMD_NOP, 2'h0, 1'b0, 10'h0, ~dq_in, 1'b1, 1'b1);
    i_ssp_ctl_model.op(`SDR_CMD_WRITE, 2'h2, 1'b0, 10'h0, 8'h77, 1'b0, 1'b1);
    grab(16'hffff, 16'h0);
    `CHK(got[0][8], 1'b0)
    `CHK(got[1][8], 1'b0)
    `CHK(got[2][8], 1'b0)
    nop(2);
    stat(8'h04);
    $display("test auto precharge finished");
  endtask

  task automatic t_pd;
    op(`SDR_CMD_NOP, 2'h0, 1'b0, ~dq_in, 1'b0);
    op(`SDR_CMD_NOP, 2'h0, 1'b0, ~dq_in, 1'b0);
    stat(8'h34);
    op(`SDR_CMD_ACTIVATE, 2'h3, 1'b0, ~dq_in, 1'b0);
    op(`SDR_CMD_NOP, 2'h0, 1'b0, ~dq_in, 1'b1);
    nop(2);
    stat(8'h04);
    op(`SDR_CMD_PRECHARGE, 2'h0, 1'b1, ~dq_in, 1'b1);
    nop(2);
    op(`SDR_CMD_NOP, 2'h0, 1'b0, ~dq_in, 1'b0);
    stat(8'h10);
    op(`SDR_CMD_NOP, 2'h0, 1'b0, ~dq_in, 1'b1);
    nop(2);
    stat(8'h00);
    $display("test power down finished");
  endtask

  initial
  begin
    #800000;
    fails++;
    print_verdict();
  end

  initial
  begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs();
    t_pre();
    t_burst();
    t_susp();
    t_cap();
    t_pd();
    print_verdict();
  end
endmodule

`default_nettype wire
